/* verilog/adcsq_pkg.sv */
// Constants shared by the converter sequencer
package adcsq_pkg;
    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_DIVIDER = 8'h95;
    localparam logic [7:0] ADDR_RESULT  = 8'h96;
    localparam logic [7:0] ADDR_CONTROL = 8'h97;
    localparam logic [7:0] ADDR_POWER   = 8'h87;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_DONE     = 0;
    localparam int BIT_GO       = 1;
    localparam int BIT_CHAN_LO  = 2;
    localparam int BIT_CHAN_HI  = 3;
    localparam int BIT_POWER_ON = 5;
    localparam int BIT_IRQ_ROUTE = 4;
    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE      = 8'h00;
    localparam int         CLK_PER_BIT   = 8;
    localparam int         RESULT_BITS   = 8;
    localparam int         OSC_HALVING   = 2;
    // Sequencer states, Gray coded
    typedef enum logic [1:0] {
        ADCSQ_IDLE   = 2'b00,
        ADCSQ_SAMPLE = 2'b01,
        ADCSQ_STEP   = 2'b11
    } adcsq_state_t;
endpackage

/* verilog/adcsq_top.sv */
// Successive approximation converter sequencer with its registers
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps
module adcsq_top #(
    parameter int DATA_W = 8
) (
    // Clock and reset
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    // Special function register port
    input  wire logic [7:0]        sfr_addr_i,
    input  wire logic              sfr_wr_i,
    input  wire logic              sfr_rd_i,
    input  wire logic [7:0]        sfr_wdata_i,
    output logic      [7:0]        sfr_rdata_o,
    // Analog front end
    output logic      [1:0]        chan_sel_o,
    output logic                   conv_power_on_o,
    output logic                   sample_hold_o,
    output logic      [DATA_W-1:0] dac_trial_o,
    input  wire logic              cmp_high_i,
    // Second external interrupt
    input  wire logic              ext_irq_pin_b_i,
    output logic                   ext_irq_line_b_o
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0]        divider_r;
    logic [7:0]        result_r;
    logic [7:0]        power_r;
    logic [1:0]        chan_r;
    logic              power_on_r;
    logic              go_r;
    logic              done_r;
    logic [7:0]        div_cnt_r;
    logic              half_r;
    logic [2:0]        sub_cnt_r;
    logic [2:0]        bit_idx_r;
    logic [DATA_W-1:0] trial_r;
    logic              cmp_s1_r;
    logic              cmp_s2_r;
    logic              pin_s1_r;
    logic              pin_s2_r;
    logic [7:0]        rdata_r;
    logic              irq_r;
    adcsq_pkg::adcsq_state_t state_r;
    adcsq_pkg::adcsq_state_t state_nxt;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire logic wr_div  = sfr_wr_i && (sfr_addr_i == adcsq_pkg::ADDR_DIVIDER);
    wire logic wr_ctl  = sfr_wr_i && (sfr_addr_i == adcsq_pkg::ADDR_CONTROL);
    wire logic wr_pwr  = sfr_wr_i && (sfr_addr_i == adcsq_pkg::ADDR_POWER);
    wire logic go_req  = wr_ctl && sfr_wdata_i[adcsq_pkg::BIT_GO];
    wire logic go_ok   = go_req && sfr_wdata_i[adcsq_pkg::BIT_POWER_ON];
    wire logic route_en = power_r[adcsq_pkg::BIT_IRQ_ROUTE];
    wire logic [1:0] chan_wr = sfr_wdata_i[adcsq_pkg::BIT_CHAN_HI:
                                           adcsq_pkg::BIT_CHAN_LO];
    wire logic       pwr_wr  = sfr_wdata_i[adcsq_pkg::BIT_POWER_ON];

    // Sequencer phase decode
    wire logic in_idle   = (state_r == adcsq_pkg::ADCSQ_IDLE);
    wire logic in_sample = (state_r == adcsq_pkg::ADCSQ_SAMPLE);
    wire logic in_step   = (state_r == adcsq_pkg::ADCSQ_STEP);
    // Start taken only while idle, so a busy start cannot strand done
    wire logic go_take   = go_ok && in_idle;

    // ------------------------------------------------------------
    // Converter timing
    // ------------------------------------------------------------
    // Converter clock tick: half rate then divider plus one
    wire logic div_wrap = (div_cnt_r == divider_r);
    wire logic conv_tick = half_r && div_wrap;
    wire logic last_sub  = (sub_cnt_r == 3'(adcsq_pkg::CLK_PER_BIT - 1));
    wire logic last_bit  = (bit_idx_r == 3'h0);
    wire logic step_end  = conv_tick && last_sub;
    wire logic conv_end  = (state_r == adcsq_pkg::ADCSQ_STEP) && step_end
                           && last_bit;

    // ------------------------------------------------------------
    // Successive approximation
    // ------------------------------------------------------------
    // Trial bit decided at the end of each step, MSB first
    function automatic logic [DATA_W-1:0] sar_next(
        input logic [DATA_W-1:0] trial,
        input logic [2:0]        idx,
        input logic              keep
    );
        logic [DATA_W-1:0] t;
        t = trial;
        t[idx] = keep;
        if (idx != 3'h0) begin
            t[idx - 3'h1] = 1'b1;
        end
        return t;
    endfunction

    // ------------------------------------------------------------
    // Sequencer control
    // ------------------------------------------------------------
    // Next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            adcsq_pkg::ADCSQ_IDLE: begin
                if (go_take) begin
                    state_nxt = adcsq_pkg::ADCSQ_SAMPLE;
                end
            end
            adcsq_pkg::ADCSQ_SAMPLE: begin
                state_nxt = adcsq_pkg::ADCSQ_STEP;
            end
            adcsq_pkg::ADCSQ_STEP: begin
                if (!power_on_r || conv_end) begin
                    state_nxt = adcsq_pkg::ADCSQ_IDLE;
                end
            end
            default: begin
                state_nxt = adcsq_pkg::ADCSQ_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Read mux, reserved control bits read zero
    wire logic [7:0] ctl_view = {2'h0, power_on_r, 1'b0, chan_r,
                                 go_r, done_r};
    wire logic [7:0] rd_mux =
        (sfr_addr_i == adcsq_pkg::ADDR_DIVIDER) ? divider_r :
        (sfr_addr_i == adcsq_pkg::ADDR_RESULT)  ? result_r  :
        (sfr_addr_i == adcsq_pkg::ADDR_CONTROL) ? ctl_view  :
        (sfr_addr_i == adcsq_pkg::ADDR_POWER)   ? power_r   :
        adcsq_pkg::RST_BYTE;

    // Interrupt source: done flag or synchronised pin
    wire logic irq_nxt = route_en ? done_r : pin_s2_r;

    // ------------------------------------------------------------
    // Registers written by software
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            divider_r  <= adcsq_pkg::RST_BYTE;
            power_r    <= adcsq_pkg::RST_BYTE;
            chan_r     <= 2'h0;
            power_on_r <= 1'b0;
        end else begin
            if (wr_div) begin
                divider_r <= sfr_wdata_i;
            end
            if (wr_pwr) begin
                power_r <= sfr_wdata_i;
            end
            if (wr_ctl) begin
                chan_r     <= chan_wr;
                power_on_r <= pwr_wr;
            end
        end
    end

    // Go bit pulses for one cycle
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            go_r <= 1'b0;
        end else begin
            go_r <= go_take;
        end
    end

    // Converter clock divider, halted while idle
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_cnt_r <= adcsq_pkg::RST_BYTE;
            half_r    <= 1'b0;
        end else if (in_idle) begin
            div_cnt_r <= adcsq_pkg::RST_BYTE;
            half_r    <= 1'b0;
        end else begin
            half_r <= ~half_r;
            if (half_r) begin
                div_cnt_r <= div_wrap ? adcsq_pkg::RST_BYTE
                                      : div_cnt_r + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Conversion engine
    // ------------------------------------------------------------
    // Sequencer state, step counters and approximation register
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r   <= adcsq_pkg::ADCSQ_IDLE;
            sub_cnt_r <= 3'h0;
            bit_idx_r <= 3'h0;
            trial_r   <= '0;
        end else begin
            state_r <= state_nxt;
            if (in_sample) begin
                sub_cnt_r <= 3'h0;
                bit_idx_r <= 3'(adcsq_pkg::RESULT_BITS - 1);
                trial_r   <= {1'b1, {(DATA_W-1){1'b0}}};
            end else if (conv_tick) begin
                sub_cnt_r <= sub_cnt_r + 3'h1;
            end
            if (in_step && step_end) begin
                trial_r   <= sar_next(trial_r, bit_idx_r, !cmp_s2_r);
                bit_idx_r <= bit_idx_r - 3'h1;
            end
        end
    end

    // Result register, untouched by an aborted conversion
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            result_r <= adcsq_pkg::RST_BYTE;
        end else if (conv_end) begin
            result_r <= 8'(sar_next(trial_r, bit_idx_r,
                                    !cmp_s2_r));
        end
    end

    // Done flag: taken start clears, completion or power off sets
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            done_r <= 1'b1;
        end else if (go_take) begin
            done_r <= 1'b0;
        end else if (conv_end || !power_on_r) begin
            done_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Synchronisers, read data and interrupt line
    // ------------------------------------------------------------
    // Two flip-flops on each asynchronous input
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cmp_s1_r <= 1'b0;
            cmp_s2_r <= 1'b0;
            pin_s1_r <= 1'b1;
            pin_s2_r <= 1'b1;
        end else begin
            cmp_s1_r <= cmp_high_i;
            cmp_s2_r <= cmp_s1_r;
            pin_s1_r <= ext_irq_pin_b_i;
            pin_s2_r <= pin_s1_r;
        end
    end

    // Read data held until the next read
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_r <= adcsq_pkg::RST_BYTE;
        end else if (sfr_rd_i) begin
            rdata_r <= rd_mux;
        end
    end

    // Interrupt line, idles high after reset
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_r <= 1'b1;
        end else begin
            irq_r <= route_en ? ~irq_nxt : irq_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic              sh_r;
    logic [1:0]        chan_o_r;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sh_r     <= 1'b0;
            chan_o_r <= 2'h0;
        end else begin
            sh_r     <= (state_nxt == adcsq_pkg::ADCSQ_SAMPLE);
            chan_o_r <= chan_r;
        end
    end

    assign sfr_rdata_o      = rdata_r;
    assign chan_sel_o       = chan_o_r;
    assign conv_power_on_o  = power_on_r;
    assign sample_hold_o    = sh_r;
    assign dac_trial_o      = trial_r;
    assign ext_irq_line_b_o = irq_r;

endmodule // adcsq_top

/* tb/adcsq_top_props.sv */
// Port checker for the converter sequencer
`timescale 1ns/1ps
module adcsq_top_props #(
    parameter int DATA_W = 8
) (
    input wire logic       sys_clk_i,
    input wire logic       rst_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic       sfr_wr_i,
    input wire logic       sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic [1:0] chan_sel_o,
    input wire logic       conv_power_on_o,
    input wire logic       sample_hold_o,
    input wire logic       ext_irq_pin_b_i,
    input wire logic       ext_irq_line_b_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // Control and power register accesses decoded
    wire logic wr_ctl = sfr_wr_i && (sfr_addr_i == adcsq_pkg::ADDR_CONTROL);
    wire logic rd_ctl = sfr_rd_i && (sfr_addr_i == adcsq_pkg::ADDR_CONTROL);
    wire logic wr_pwr = sfr_wr_i && (sfr_addr_i == adcsq_pkg::ADDR_POWER);
    logic       route_r;
    logic [2:0] age_r;
    // Copy of the routing bit and cycles since reset, saturating at 4
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            route_r <= 1'b0;
            age_r   <= 3'h0;
        end else begin
            route_r <= wr_pwr ? sfr_wdata_i[adcsq_pkg::BIT_IRQ_ROUTE] : route_r;
            age_r   <= age_r[2] ? age_r : age_r + 3'h1;
        end
    end
    property p_start_once;
        sample_hold_o |-> $past(wr_ctl && sfr_wdata_i[5] && sfr_wdata_i[1])
            ##1 !sample_hold_o;
    endproperty
    a_start_once: assert property (p_start_once)
        else $error("sample pulse without a powered start write");
    property p_no_start_off;
        wr_ctl && !sfr_wdata_i[5] |=> !sample_hold_o;
    endproperty
    a_no_start_off: assert property (p_no_start_off)
        else $error("start taken while powered down");
    // Channel output is a second register stage behind the write
    property p_chan;
        wr_ctl |=> ##1 (chan_sel_o == $past(sfr_wdata_i[3:2], 2));
    endproperty
    a_chan: assert property (p_chan)
        else $error("channel select does not follow write");
    property p_power;
        wr_ctl |=> conv_power_on_o == $past(sfr_wdata_i[5]);
    endproperty
    a_power: assert property (p_power)
        else $error("power enable does not follow write");
    property p_resv;
        rd_ctl |=> sfr_rdata_o[7:6] == 2'b00 && !sfr_rdata_o[4];
    endproperty
    a_resv: assert property (p_resv)
        else $error("reserved control bits read nonzero");
    property p_go_read;
        rd_ctl && !sample_hold_o |=> !sfr_rdata_o[1];
    endproperty
    a_go_read: assert property (p_go_read)
        else $error("go bit stuck high");
    property p_busy;
        rd_ctl && $past(sample_hold_o) |=> !sfr_rdata_o[0];
    endproperty
    a_busy: assert property (p_busy)
        else $error("done flag high during conversion");
    property p_route_hold;
        route_r && sample_hold_o |-> ##[1:2] ext_irq_line_b_o[*8];
    endproperty
    a_route_hold: assert property (p_route_hold)
        else $error("routed interrupt line not high while converting");
    property p_pin_follow;
        (!route_r)[*4] ##0 age_r[2] |->
            ext_irq_line_b_o == $past(ext_irq_pin_b_i, 3);
    endproperty
    a_pin_follow: assert property (p_pin_follow)
        else $error("interrupt line does not follow pin");
endmodule // adcsq_top_props
bind adcsq_top adcsq_top_props #(.DATA_W(DATA_W)) u_props (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .chan_sel_o(chan_sel_o),
    .conv_power_on_o(conv_power_on_o), .sample_hold_o(sample_hold_o),
    .ext_irq_pin_b_i(ext_irq_pin_b_i), .ext_irq_line_b_o(ext_irq_line_b_o));

/* tb/adcsq_afe_model.sv */
// Comparator and input levels standing in for the analog front end
`timescale 1ns/1ps
module adcsq_afe_model #(
    parameter logic [31:0] LEVELS = 32'h0000_0000
) (
    input  wire logic       sys_clk_i,
    input  wire logic [1:0] chan_sel_i,
    input  wire logic       power_i,
    input  wire logic [7:0] trial_i,
    output logic            cmp_high_o
);
    logic [7:0] level;
    logic       junk_r = 1'b0;
    // Input picked by the channel select
    assign level = LEVELS[8*chan_sel_i +: 8];
    // Meaningless toggling while unpowered
    always @(posedge sys_clk_i) junk_r <= ~junk_r;
    // Trial above the held level rejects the bit
    assign cmp_high_o = power_i ? (level < trial_i) : junk_r;
endmodule // adcsq_afe_model

/* tb/testbench.sv */
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module testbench;
    localparam logic [31:0] LEVELS = 32'hA55A_FF00;
    localparam logic [7:0]  DIV = adcsq_pkg::ADDR_DIVIDER;
    localparam logic [7:0]  RES = adcsq_pkg::ADDR_RESULT;
    localparam logic [7:0]  CTL = adcsq_pkg::ADDR_CONTROL;
    logic       sys_clk_i, rst_i, sfr_wr_i, sfr_rd_i, cmp_high_i, pin;
    logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, dac_trial_o, v;
    logic [1:0] chan_sel_o;
    logic       power_on, sample_hold, irq_line;
    int         err_count = 0;
    int         tests_run = 0;
    adcsq_top u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
        .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
        .chan_sel_o(chan_sel_o), .conv_power_on_o(power_on),
        .sample_hold_o(sample_hold), .dac_trial_o(dac_trial_o),
        .cmp_high_i(cmp_high_i), .ext_irq_pin_b_i(pin),
        .ext_irq_line_b_o(irq_line));
    adcsq_afe_model #(.LEVELS(LEVELS)) u_afe (.sys_clk_i(sys_clk_i),
        .chan_sel_i(chan_sel_o), .power_i(power_on), .trial_i(dac_trial_o),
        .cmp_high_o(cmp_high_i));
    // Clock
    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(negedge sys_clk_i);
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        @(negedge sys_clk_i);
        sfr_wr_i = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk_i);
        sfr_addr_i = a;
        sfr_rd_i = 1'b1;
        @(negedge sys_clk_i);
        sfr_rd_i = 1'b0;
        d = sfr_rdata_o;
    endtask
    // Divider first, then a powered start; poll done and time it
    // Analog pin functions taken as already selected
    task automatic convert(input logic [1:0] ch, input logic [7:0] dv,
                           input logic idle_irq);
        int n;
        wr(DIV, dv);
        wr(CTL, {4'h2, ch, 2'b10});
        rd(CTL, v);
        check("ctl busy", v, {4'h2, ch, 2'b00});
        check("chan", {6'h00, chan_sel_o}, {6'h00, ch});
        check("irq busy", {7'h00, irq_line}, 8'h01);
        n = 2;
        do begin
            rd(CTL, v);
            n += 2;
        end while (v[0] !== 1'b1 && n < 2000);
        if (n >= 2000) begin
            err_count++;
            summarize();
        end
        check("duration", {7'h00, n >= 128 * (dv + 1) && n <= 128 * (dv + 1)
            + 8}, 8'h01);
        rd(RES, v);
        check("result", v, LEVELS[8*ch +: 8]);
        @(negedge sys_clk_i);
        check("irq done", {7'h00, irq_line},
              {7'h00, idle_irq});
    endtask
    // Main sequence
    initial begin
        rst_i = 1'b1;
        {sfr_wr_i, sfr_rd_i, sfr_addr_i, sfr_wdata_i} = 18'h0_0000;
        pin = 1'b1;
        repeat (20) @(negedge sys_clk_i);
        rst_i = 1'b0;
        rd(DIV, v);
        check("divider reset", v, 8'h00);
        rd(RES, v);
        check("result reset", v, 8'h00);
        rd(CTL, v);
        check("control reset", v, 8'h01);
        rd(8'h90, v);
        check("unmapped", v, 8'h00);
        wr(DIV, 8'hA5);
        rd(DIV, v);
        check("divider rw", v, 8'hA5);
        wr(CTL, 8'hD0);
        rd(CTL, v);
        check("reserved", v, 8'h01);
        check("power off", {7'h00, power_on}, 8'h00);
        for (int ch = 0; ch < 4; ch++) begin
            convert(ch[1:0], {7'h00, ch[0]}, 1'b1);
        end
        check("power on", {7'h00, power_on}, 8'h01);
        wr(CTL, 8'h02);
        rd(CTL, v);
        check("start refused", v, 8'h01);
        rd(RES, v);
        check("result kept", v, 8'hA5);
        pin = 1'b0;
        repeat (4) @(negedge sys_clk_i);
        check("pin follow", {7'h00, irq_line}, 8'h00);
        pin = 1'b1;
        wr(adcsq_pkg::ADDR_POWER, 8'h10);
        convert(2'h1, 8'h02, 1'b0);
        summarize();
    end
endmodule // testbench
